// ---- hdl/arp_pkg.sv ----
package arp_pkg;

  // ****************************************
  // bus and register map
  // ****************************************
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          NUM_CH          = 8;
  localparam int          RES_W           = 10;
  localparam int          POS_W           = 3;
  localparam logic [7:0]  OFS_DONE_FLAGS  = 8'h00;
  localparam logic [7:0]  OFS_DIG_IN_EN   = 8'h04;
  localparam logic [7:0]  OFS_PIN_PORT    = 8'h08;
  localparam logic [7:0]  OFS_SEQ_START   = 8'h0C;
  localparam logic [7:0]  OFS_CONV_CFG    = 8'h10;
  localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h14;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h18;
  localparam logic [7:0]  OFS_RESULT_BASE = 8'h20;
  localparam logic [7:0]  RESULT_SPAN     = 8'h20;

  // ****************************************
  // field positions
  // ****************************************
  localparam int          SEQ_JUSTIFY_BIT = 0;
  localparam int          SEQ_SIGNED_BIT  = 1;
  localparam int          CFG_FFC_BIT     = 0;
  localparam int          CFG_ETRIG_BIT   = 1;
  localparam int          CFG_TSRC_BIT    = 2;
  localparam int          CFG_TCH_LSB     = 4;
  localparam int          RES_LEFT_SHIFT  = 6;

  // ****************************************
  // reset values and responses
  // ****************************************
  localparam logic [7:0]  RST_FLAGS       = 8'h00;
  localparam logic [7:0]  RST_DIG_IN_EN   = 8'h00;
  localparam logic [7:0]  RST_PIN_PORT    = 8'hFF;
  localparam logic [15:0] RST_RESULT      = 16'h0000;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic             valid;
    logic [POS_W-1:0] pos;
    logic [RES_W-1:0] data;
  } arp_conv_result_t;

  typedef struct packed {
    logic             ext_trigger_on;
    logic             trigger_source_select;
    logic [POS_W-1:0] trigger_channel_select;
  } arp_trig_cfg_t;

  typedef struct packed {
    logic start;
    logic justify_select;
    logic signed_select;
  } arp_seq_ctl_t;

endpackage

// ---- hdl/arp_top.sv ----
// Functional notes
// R1 - eight done flags; flag x sets when conversion x lands in result x
// R2 - any write to sequence start control clears all done flags
// R3 - fast clear off: flag read then result x read clears flag x
// R4 - fast clear on: any read of result x clears flag x
// R5 - sequence start clear beats set; set beats read clears
// R6 - done flag register always readable; writes ignored
// R7 - input enable bit x opens digital path from pin x to port bit x
// R8 - port bit returns pin level if enabled or active trigger pin, source 0
// R9 - disabled, non-trigger port bit reads one
// R10 - reset sets all port bits to one; writes ignored
// R11 - port bit x reflects analog pin x
// R12 - eight result registers, read-only in normal operation
// R13 - justify select chooses left or right alignment
// R14 - signed with left justify stores two's complement
// R15 - signed with right justify ignored; result unsigned
// R16 - result writes only in special mode; ignored otherwise
// R17 - flag register read returns flags unchanged, only arms read clear
`timescale 1ns/1ps
`default_nettype none
module arp_top
  import arp_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic [arp_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [arp_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [arp_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [arp_pkg::DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire arp_pkg::arp_conv_result_t     conv_result,
  input  wire logic [arp_pkg::NUM_CH-1:0]    analog_input_pin,
  input  wire logic                          special_mode,
  output arp_pkg::arp_seq_ctl_t              seq_ctl,
  output arp_pkg::arp_trig_cfg_t             trig_cfg,
  output logic                               fast_flag_clear,
  output logic [arp_pkg::NUM_CH-1:0]         input_buffer_on,
  output logic                               irq
);
  import arp_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic                  aw_hold_r;
  logic                  aw_hold_nxt;
  logic                  w_hold_r;
  logic                  w_hold_nxt;
  logic [ADDR_W-1:0]     waddr_r;
  logic [DATA_W-1:0]     wdata_r;
  logic [3:0]            wstrb_r;
  logic                  awready_r;
  logic                  awready_nxt;
  logic                  wready_r;
  logic                  wready_nxt;
  logic                  bvalid_r;
  logic                  bvalid_nxt;
  logic [1:0]            bresp_r;
  logic                  arready_r;
  logic                  arready_nxt;
  logic                  rvalid_r;
  logic                  rvalid_nxt;
  logic [DATA_W-1:0]     rdata_r;
  logic [1:0]            rresp_r;
  logic                  do_write;
  logic                  do_read;
  logic                  lane0;
  logic                  lane1;
  logic                  wr_dig_in_en;
  logic                  wr_seq_start;
  logic                  wr_conv_cfg;
  logic                  wr_irq_status;
  logic                  wr_irq_mask;
  logic                  wr_result_area;
  logic                  wr_mapped;
  logic                  rd_done_flags;
  logic                  rd_result_area;
  logic                  rd_mapped;
  logic [POS_W-1:0]      wr_res_idx;
  logic [POS_W-1:0]      rd_res_idx;
  logic [DATA_W-1:0]     rd_mux;
  logic [NUM_CH-1:0]     done_flag_r;
  logic [NUM_CH-1:0]     done_flag_nxt;
  logic [NUM_CH-1:0]     armed_r;
  logic [NUM_CH-1:0]     armed_nxt;
  logic [NUM_CH-1:0]     flag_set;
  logic [NUM_CH-1:0]     res_read;
  logic [NUM_CH-1:0]     read_clear;
  logic [NUM_CH-1:0]     dig_in_en_r;
  logic [NUM_CH-1:0]     pin_level_port_r;
  logic [NUM_CH-1:0]     pin_s1_r;
  logic [NUM_CH-1:0]     pin_s2_r;
  logic [NUM_CH-1:0]     pin_s3_r;
  logic [NUM_CH-1:0]     pin_filt_r;
  logic [NUM_CH-1:0]     trig_pin;
  logic [NUM_CH-1:0]     buf_on_r;
  logic [NUM_CH-1:0]     irq_status_r;
  logic [NUM_CH-1:0]     irq_mask_r;
  logic                  irq_r;
  logic [2:0]            spec_sync_r;
  logic                  special_r;
  logic                  justify_r;
  logic                  signed_r;
  logic                  start_r;
  logic                  ffc_r;
  logic                  etrig_r;
  logic                  tsrc_r;
  logic [POS_W-1:0]      tch_r;
  logic [15:0]           result_r [NUM_CH];
  logic [15:0]           fmt_result;

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  assign do_write    = aw_hold_r & w_hold_r & ~bvalid_r;
  assign aw_hold_nxt = do_write ? 1'b0 : (aw_hold_r | (s_axi_awvalid & awready_r));
  assign w_hold_nxt  = do_write ? 1'b0 : (w_hold_r | (s_axi_wvalid & wready_r));
  assign bvalid_nxt  = do_write | (bvalid_r & ~s_axi_bready);
  assign awready_nxt = ~aw_hold_nxt & ~bvalid_nxt;
  assign wready_nxt  = ~w_hold_nxt & ~bvalid_nxt;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      if (do_write) begin
        bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      waddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid & awready_r) begin
        waddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & wready_r) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  // ****************************************
  // write decode
  // ****************************************
  assign lane0          = wstrb_r[0];
  assign lane1          = wstrb_r[1];
  assign wr_res_idx     = waddr_r[POS_W+1:2];
  assign wr_result_area = do_write & (waddr_r >= OFS_RESULT_BASE)
                          & (waddr_r < OFS_RESULT_BASE + RESULT_SPAN);
  assign wr_dig_in_en   = do_write & (waddr_r == OFS_DIG_IN_EN) & lane0;
  assign wr_seq_start   = do_write & (waddr_r == OFS_SEQ_START);
  assign wr_conv_cfg    = do_write & (waddr_r == OFS_CONV_CFG) & lane0;
  assign wr_irq_status  = do_write & (waddr_r == OFS_IRQ_STATUS) & lane0;
  assign wr_irq_mask    = do_write & (waddr_r == OFS_IRQ_MASK) & lane0;
  // flags and port offsets are mapped but writes are dropped [R6] [R10]
  assign wr_mapped      = (waddr_r == OFS_DONE_FLAGS) | (waddr_r == OFS_DIG_IN_EN)
                          | (waddr_r == OFS_PIN_PORT) | (waddr_r == OFS_SEQ_START)
                          | (waddr_r == OFS_CONV_CFG) | (waddr_r == OFS_IRQ_STATUS)
                          | (waddr_r == OFS_IRQ_MASK)
                          | ((waddr_r >= OFS_RESULT_BASE) & (waddr_r < OFS_RESULT_BASE + RESULT_SPAN));

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  assign do_read        = s_axi_arvalid & arready_r;
  assign rvalid_nxt     = do_read | (rvalid_r & ~s_axi_rready);
  assign arready_nxt    = ~rvalid_nxt;
  assign rd_res_idx     = s_axi_araddr[POS_W+1:2];
  assign rd_result_area = (s_axi_araddr >= OFS_RESULT_BASE)
                          & (s_axi_araddr < OFS_RESULT_BASE + RESULT_SPAN);
  assign rd_done_flags  = do_read & (s_axi_araddr == OFS_DONE_FLAGS);
  assign rd_mapped      = (s_axi_araddr == OFS_DONE_FLAGS) | (s_axi_araddr == OFS_DIG_IN_EN)
                          | (s_axi_araddr == OFS_PIN_PORT) | (s_axi_araddr == OFS_SEQ_START)
                          | (s_axi_araddr == OFS_CONV_CFG) | (s_axi_araddr == OFS_IRQ_STATUS)
                          | (s_axi_araddr == OFS_IRQ_MASK) | rd_result_area;

  always_comb begin
    rd_mux = '0;
    case (s_axi_araddr)
      OFS_DONE_FLAGS: rd_mux[NUM_CH-1:0] = done_flag_r;          // [R6] [R17]
      OFS_DIG_IN_EN:  rd_mux[NUM_CH-1:0] = dig_in_en_r;          // [R7]
      OFS_PIN_PORT:   rd_mux[NUM_CH-1:0] = pin_level_port_r;     // [R11]
      OFS_SEQ_START: begin
        rd_mux[SEQ_JUSTIFY_BIT] = justify_r;
        rd_mux[SEQ_SIGNED_BIT]  = signed_r;
      end
      OFS_CONV_CFG: begin
        rd_mux[CFG_FFC_BIT]                    = ffc_r;
        rd_mux[CFG_ETRIG_BIT]                  = etrig_r;
        rd_mux[CFG_TSRC_BIT]                   = tsrc_r;
        rd_mux[CFG_TCH_LSB+POS_W-1:CFG_TCH_LSB] = tch_r;
      end
      OFS_IRQ_STATUS: rd_mux[NUM_CH-1:0] = irq_status_r;
      OFS_IRQ_MASK:   rd_mux[NUM_CH-1:0] = irq_mask_r;
      default: begin
        if (rd_result_area) begin
          rd_mux[15:0] = result_r[rd_res_idx];                   // [R12]
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else begin
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      if (do_read) begin
        rdata_r <= rd_mux;
        rresp_r <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dig_in_en_r <= RST_DIG_IN_EN;
      justify_r   <= 1'b0;
      signed_r    <= 1'b0;
      start_r     <= 1'b0;
      ffc_r       <= 1'b0;
      etrig_r     <= 1'b0;
      tsrc_r      <= 1'b0;
      tch_r       <= '0;
      irq_mask_r  <= '0;
    end else begin
      start_r <= wr_seq_start;
      if (wr_dig_in_en) begin
        dig_in_en_r <= wdata_r[NUM_CH-1:0];                      // [R7]
      end
      if (wr_seq_start & lane0) begin
        justify_r <= wdata_r[SEQ_JUSTIFY_BIT];
        signed_r  <= wdata_r[SEQ_SIGNED_BIT];
      end
      if (wr_conv_cfg) begin
        ffc_r   <= wdata_r[CFG_FFC_BIT];
        etrig_r <= wdata_r[CFG_ETRIG_BIT];
        tsrc_r  <= wdata_r[CFG_TSRC_BIT];
        tch_r   <= wdata_r[CFG_TCH_LSB+POS_W-1:CFG_TCH_LSB];
      end
      if (wr_irq_mask) begin
        irq_mask_r <= wdata_r[NUM_CH-1:0];
      end
    end
  end

  // ****************************************
  // special mode strap sync
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      spec_sync_r <= 3'h0;
      special_r   <= 1'b0;
    end else begin
      spec_sync_r <= {spec_sync_r[1:0], special_mode};
      if (spec_sync_r[1] == spec_sync_r[2]) begin
        special_r <= spec_sync_r[2];
      end
    end
  end

  // ****************************************
  // done flags, read clear, pin port
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      assign flag_set[gi]   = conv_result.valid & (conv_result.pos == POS_W'(gi));  // [R1]
      assign res_read[gi]   = do_read & rd_result_area & (rd_res_idx == POS_W'(gi));
      assign read_clear[gi] = res_read[gi] & (ffc_r | armed_r[gi]);                 // [R3] [R4]
      assign trig_pin[gi]   = etrig_r & ~tsrc_r & (tch_r == POS_W'(gi));            // [R8]

      always_comb begin
        if (wr_seq_start) begin
          done_flag_nxt[gi] = 1'b0;                              // [R2] [R5]
        end else if (flag_set[gi]) begin
          done_flag_nxt[gi] = 1'b1;                              // [R5]
        end else if (read_clear[gi]) begin
          done_flag_nxt[gi] = 1'b0;
        end else begin
          done_flag_nxt[gi] = done_flag_r[gi];
        end
        if (wr_seq_start | res_read[gi]) begin
          armed_nxt[gi] = 1'b0;
        end else if (rd_done_flags) begin
          armed_nxt[gi] = 1'b1;                                  // [R17]
        end else begin
          armed_nxt[gi] = armed_r[gi];
        end
      end

      always_ff @(posedge clk) begin
        if (!reset_n) begin
          pin_level_port_r[gi] <= RST_PIN_PORT[gi];              // [R10]
          pin_filt_r[gi]       <= 1'b1;
          buf_on_r[gi]         <= 1'b0;
        end else begin
          if (pin_s2_r[gi] == pin_s3_r[gi]) begin
            pin_filt_r[gi] <= pin_s3_r[gi];
          end
          buf_on_r[gi] <= dig_in_en_r[gi] | trig_pin[gi];        // [R7]
          if (dig_in_en_r[gi] | trig_pin[gi]) begin
            pin_level_port_r[gi] <= pin_filt_r[gi];              // [R8] [R11]
          end else begin
            pin_level_port_r[gi] <= 1'b1;                        // [R9]
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_s1_r <= '1;
      pin_s2_r <= '1;
      pin_s3_r <= '1;
    end else begin
      pin_s1_r <= analog_input_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done_flag_r <= RST_FLAGS;
      armed_r     <= '0;
    end else begin
      done_flag_r <= done_flag_nxt;
      armed_r     <= armed_nxt;
    end
  end

  // ****************************************
  // result formatting and storage
  // ****************************************
  always_comb begin
    if (justify_r) begin
      fmt_result = {conv_result.data, 6'h00};                    // [R13]
      if (signed_r) begin
        fmt_result[15] = ~conv_result.data[RES_W-1];             // [R14]
      end
    end else begin
      fmt_result = {6'h00, conv_result.data};                    // [R13] [R15]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        result_r[i] <= RST_RESULT;
      end
    end else begin
      if (conv_result.valid) begin
        result_r[conv_result.pos] <= fmt_result;                 // [R1] [R12]
      end else if (wr_result_area & special_r) begin
        if (lane0) begin
          result_r[wr_res_idx][7:0] <= wdata_r[7:0];             // [R16]
        end
        if (lane1) begin
          result_r[wr_res_idx][15:8] <= wdata_r[15:8];           // [R16]
        end
      end
    end
  end

  // ****************************************
  // interrupt
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_status_r <= '0;
      irq_r        <= 1'b0;
    end else begin
      irq_status_r <= flag_set
                      | (irq_status_r & ~(wr_irq_status ? wdata_r[NUM_CH-1:0] : {NUM_CH{1'b0}}));
      irq_r        <= |(irq_status_r & irq_mask_r);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready                  = awready_r;
  assign s_axi_wready                   = wready_r;
  assign s_axi_bvalid                   = bvalid_r;
  assign s_axi_bresp                    = bresp_r;
  assign s_axi_arready                  = arready_r;
  assign s_axi_rvalid                   = rvalid_r;
  assign s_axi_rdata                    = rdata_r;
  assign s_axi_rresp                    = rresp_r;
  assign seq_ctl.start                  = start_r;
  assign seq_ctl.justify_select         = justify_r;
  assign seq_ctl.signed_select          = signed_r;
  assign trig_cfg.ext_trigger_on        = etrig_r;
  assign trig_cfg.trigger_source_select = tsrc_r;
  assign trig_cfg.trigger_channel_select = tch_r;
  assign fast_flag_clear                = ffc_r;
  assign input_buffer_on                = buf_on_r;
  assign irq                            = irq_r;

endmodule
`default_nettype wire

// ---- verif/arp_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module arp_sva
  import arp_pkg::*;
(
  input wire logic                       clk,
  input wire logic                       reset_n,
  input wire logic [arp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic [arp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [arp_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]                 s_axi_rresp,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire arp_pkg::arp_seq_ctl_t      seq_ctl,
  input wire arp_pkg::arp_trig_cfg_t     trig_cfg,
  input wire logic [arp_pkg::NUM_CH-1:0] input_buffer_on,
  input wire logic                       irq
);
  // ****************************************
  // expected responses
  // ****************************************
  logic [1:0] wr_rsp_r;

  function automatic logic [1:0] rsp(input logic [7:0] a);
    return ((a[1:0] == 2'h0 && a <= OFS_IRQ_MASK)
            || (a >= OFS_RESULT_BASE && a < OFS_RESULT_BASE + RESULT_SPAN)) ? RESP_OKAY : RESP_SLVERR;
  endfunction

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_rsp_r <= RESP_OKAY;
    end else if (s_axi_awvalid && s_axi_awready) begin
      wr_rsp_r <= rsp(s_axi_awaddr);
    end
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && s_axi_rresp == rsp($past(s_axi_araddr))) else $error("read answer late or wrong");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data not held");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
  wr_resp_a: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp == wr_rsp_r)
    else $error("wrong write response");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  start_pulse_a: assert property (seq_ctl.start |=> !seq_ctl.start)
    else $error("start longer than one cycle");
  start_cause_a: assert property (seq_ctl.start |-> $rose(s_axi_bvalid))
    else $error("start without write");
  trig_path_a: assert property ($past(trig_cfg.ext_trigger_on) && !$past(trig_cfg.trigger_source_select)
    |-> input_buffer_on[$past(trig_cfg.trigger_channel_select)]) else $error("trigger pin buffer off");

  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  cover property (seq_ctl.start);
  cover property ($rose(irq));
endmodule
bind arp_top arp_sva u_sva (.*);
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_top;
  import arp_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic              clk = 1'b0, reset_n = 1'b0, special_mode = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic              fast_flag_clear, irq;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r;
  logic [NUM_CH-1:0] analog_input_pin = 8'h00, input_buffer_on;
  arp_conv_result_t  conv_result = '0;
  arp_seq_ctl_t      seq_ctl;
  arp_trig_cfg_t     trig_cfg;
  int                n_errors = 0, checks = 0;
  logic [31:0]       fmt[4] = '{32'h2A5, 32'hA940, 32'h2A5, 32'h2940};

  arp_top u_dut (.*);
  always #5 clk = ~clk;

  // ****************************************
  // tasks
  // ****************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic hang(input int n);
    if (n >= 50) begin
      `CHK("handshake", 1'b1, 1'b0)
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    hang(n);
  endtask
  task automatic rd(input logic [7:0] a, input arp_conv_result_t c = '0);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    conv_result <= c;
    do begin
      @(posedge clk);
      n++;
      conv_result.valid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    hang(n);
  endtask
  task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(s, e, d)
  endtask
  task automatic cv(input logic [2:0] p, input logic [9:0] v);
    @(posedge clk);
    conv_result <= '{1'b1, p, v};
    @(posedge clk);
    conv_result.valid <= 1'b0;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rdc("flags", OFS_DONE_FLAGS, 32'h0);
    rdc("dien", OFS_DIG_IN_EN, 32'h0);
    rdc("port", OFS_PIN_PORT, 32'hFF);
    rdc("res7", OFS_RESULT_BASE + 8'h1C, 32'h0);
    $display("test reset done");
    analog_input_pin <= 8'h5A;
    wr(OFS_DIG_IN_EN, 32'h0F);
    wr(OFS_PIN_PORT, 32'h00);
    repeat (8) @(posedge clk);
    rdc("dien", OFS_DIG_IN_EN, 32'h0F);
    rdc("port", OFS_PIN_PORT, 32'hFA);
    wr(OFS_CONV_CFG, 32'h52);
    repeat (4) @(posedge clk);
    rdc("port", OFS_PIN_PORT, 32'hDA);
    `CHK("bufon", 8'h2F, input_buffer_on)
    `CHK("trig", 5'h15, trig_cfg)
    wr(OFS_CONV_CFG, 32'h56);
    repeat (4) @(posedge clk);
    rdc("port", OFS_PIN_PORT, 32'hFA);
    `CHK("bufon", 8'h0F, input_buffer_on)
    wr(OFS_CONV_CFG, 32'h0);
    $display("test port done");
    for (int k = 0; k < 4; k++) begin
      wr(OFS_SEQ_START, k);
      cv(3'(k), 10'h2A5);
      `CHK("seq", 2'(k), {seq_ctl.signed_select, seq_ctl.justify_select})
      rdc("flags", OFS_DONE_FLAGS, 32'h1 << k);
      rdc("fmt", OFS_RESULT_BASE + 8'(4 * k), fmt[k]);
    end
    $display("test format done");
    wr(OFS_SEQ_START, 32'h0);
    rd(OFS_RESULT_BASE + 8'h08);
    cv(3'd2, 10'h3);
    rd(OFS_RESULT_BASE + 8'h08);
    rdc("flags", OFS_DONE_FLAGS, 32'h04);
    wr(OFS_DONE_FLAGS, 32'h0);
    rdc("flags", OFS_DONE_FLAGS, 32'h04);
    rdc("res2", OFS_RESULT_BASE + 8'h08, 32'h3);
    rdc("flags", OFS_DONE_FLAGS, 32'h0);
    rd(OFS_RESULT_BASE + 8'h14);
    wr(OFS_CONV_CFG, 32'h1);
    `CHK("ffc", 1'b1, fast_flag_clear)
    cv(3'd5, 10'h1);
    rd(OFS_RESULT_BASE + 8'h14);
    rdc("flags", OFS_DONE_FLAGS, 32'h0);
    cv(3'd5, 10'h1);
    rd(OFS_RESULT_BASE + 8'h14, '{1'b1, 3'd5, 10'h2});
    rdc("flags", OFS_DONE_FLAGS, 32'h20);
    wr(OFS_SEQ_START, 32'h0);
    rdc("flags", OFS_DONE_FLAGS, 32'h0);
    wr(OFS_CONV_CFG, 32'h0);
    `CHK("ffc", 1'b0, fast_flag_clear)
    $display("test flags done");
    wr(OFS_RESULT_BASE + 8'h18, 32'h1234);
    rdc("res6", OFS_RESULT_BASE + 8'h18, 32'h0);
    special_mode <= 1'b1;
    repeat (8) @(posedge clk);
    wr(OFS_RESULT_BASE + 8'h18, 32'h1234);
    rdc("res6", OFS_RESULT_BASE + 8'h18, 32'h1234);
    special_mode <= 1'b0;
    rd(8'h1C);
    `CHK("rresp", RESP_SLVERR, r)
    wr(8'h1C, 32'h1);
    `CHK("bresp", RESP_SLVERR, r)
    $display("test access done");
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_IRQ_STATUS, 32'hFF);
    cv(3'd1, 10'h0);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    rdc("irqst", OFS_IRQ_STATUS, 32'h02);
    wr(OFS_IRQ_MASK, 32'h02);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b1, irq)
    wr(OFS_IRQ_STATUS, 32'h02);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    $display("test irq done");
    conclude();
  end
endmodule
`default_nettype wire
